// [include/rtc_pkg.sv]
// Purpose: Shared constants for the serial clock status block and its host.
// Assumes: hclk at 40 MHz, crystal time base derived from hclk.
// Notes:   Both ends compile against this package.
package rtc_pkg;
    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000; // hclk rate
    localparam int XTAL_HZ = 32_768; // crystal rate
    localparam int HALF_TICK_CYC = CLK_HZ / (2 * XTAL_HZ); // Half period
    localparam int SEC_LAG_US = 92; // Increment lag after pulse fall
    localparam int SEC_LAG_TICKS = SEC_LAG_US * XTAL_HZ / 1_000_000;
    localparam int ALARM_LAG_US = 61; // Alarm flag lag after match
    localparam int ALARM_LAG_TICKS_RAW = ALARM_LAG_US * XTAL_HZ / 1_000_000;
    localparam int ALARM_LAG_TICKS =
        (ALARM_LAG_TICKS_RAW < 1) ? 1 : ALARM_LAG_TICKS_RAW;
    localparam int ADJ_MAX_US = 3784; // Largest adjustment step
    localparam int ADJ_MAX_TICKS = ADJ_MAX_US * XTAL_HZ / 1_000_000;
    localparam int ADJ_PERIOD_S = 20; // Seconds between adjustments
    // ------------------------------------------------------------
    // Device register map (4-bit link address)
    // ------------------------------------------------------------
    localparam logic [3:0] SEC_ADDR = 4'h0; // Seconds counter
    localparam logic [3:0] ADJ_ADDR = 4'h7; // Oscillation adjustment
    localparam logic [3:0] CTRL1_ADDR = 4'he; // Control one
    localparam logic [3:0] STATUS_CONTROL_TWO_ADDR = 4'hf;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] ADJ_RESET = 8'h00;
    localparam logic [7:0] STATUS_CONTROL_TWO_RESET = 8'h10;
    // Control one fields
    localparam int C1_WEEKLY_EN = 7;
    localparam int C1_DAILY_EN = 6;
    localparam int C1_CLKOUT_DIS_B = 4;
    localparam int C1_SEL_LSB = 0; // periodic_sel bits 2:0
    // Status control two fields
    localparam int S2_VDROP_SEL = 7;
    localparam int S2_SUPPLY_LOW = 6;
    localparam int S2_SCRATCH = 5;
    localparam int S2_OSC_HALT = 4;
    localparam int S2_CLKOUT_DIS_A = 3;
    localparam int S2_PERIODIC = 2;
    localparam int S2_WEEKLY = 1;
    localparam int S2_DAILY = 0;
    // Adjustment fields
    localparam int ADJ_SIGN = 6; // 1 shortens, 0 lengthens
    // ------------------------------------------------------------
    // Host register map (AHB byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] HOST_CMD_OFS = 8'h00;
    localparam logic [7:0] HOST_STAT_OFS = 8'h04;
    localparam int CMD_READ_BIT = 16; // 1 reads, 0 writes
    localparam int CMD_ADDR_LSB = 8; // Link address 11:8
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_IRQ_A_BIT = 9;
    localparam int STAT_IRQ_B_BIT = 10;
    // Host link sequencer states
    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_CE_ON = 5'b00010,
        H_STROBE = 5'b00100,
        H_WAIT = 5'b01000,
        H_CE_OFF = 5'b10000
    } host_state_e;
endpackage

// [include/rtc_link_if.sv]
// Purpose: Link between the host controller and the clock device.
// Assumes: Single hclk domain, strobes one cycle wide.
// Notes:   Register access stands in for the serial wire protocol.
`timescale 1ns/1ps
`default_nettype none
interface rtc_link_if;
    logic ce; // Chip enable, high during access
    logic wr_stb; // Write strobe
    logic rd_stb; // Read strobe
    logic [3:0] addr; // Register address
    logic [7:0] wdata; // Write data
    logic [7:0] rdata; // Read data
    logic rd_ack; // Read data valid pulse
    logic irq_out_a_n; // Periodic / weekly alarm, low active
    logic irq_out_b_n; // Daily alarm, low active
    logic clkout_pin; // Crystal clock output
    modport device (
        input ce, wr_stb, rd_stb, addr, wdata,
        output rdata, rd_ack, irq_out_a_n, irq_out_b_n, clkout_pin
    );
    modport host (
        output ce, wr_stb, rd_stb, addr, wdata,
        input rdata, rd_ack, irq_out_a_n, irq_out_b_n, clkout_pin
    );
endinterface
`default_nettype wire

// [rtl/rtc_device.sv]
// Purpose: Periodic interrupt, status register and clock output of the RTC.
// Assumes: Crystal ticks are derived from hclk by a divider.
// Notes:   Time counters live outside; they report rollovers here.
`timescale 1ns/1ps
`default_nettype none
module rtc_device #(
    parameter int HALF_DIV = rtc_pkg::HALF_TICK_CYC // hclk per half tick
) (
    input wire logic hclk,
    input wire logic hresetn,
    rtc_link_if.device link,
    input wire logic osc_running, // Crystal oscillation sensed
    input wire logic supply_below, // Comparator below threshold
    input wire logic weekly_match, // Weekly alarm compare hit
    input wire logic daily_match, // Daily alarm compare hit
    input wire logic next_sec_zero, // Seconds roll to 00 next
    input wire logic next_min_zero, // Minutes roll to 00 next
    input wire logic next_hour_zero, // Hours roll to 00 next
    input wire logic next_day_first, // Day rolls to 1 next
    output logic vdrop_threshold_sel, // Comparator threshold select
    output logic sec_inc // Seconds increment pulse
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [9:0] half_cnt; // hclk count within half tick
        logic xtal_ph; // Crystal phase
        logic [14:0] sub; // Sub-second divider
        logic [6:0] stall; // Lengthening ticks left
        logic [1:0] lag; // Ticks until seconds increment
        logic [4:0] sec20; // Seconds since last adjustment
        logic [7:0] adj; // Oscillation adjustment
        logic [7:0] ctrl1; // Control one
        logic [7:0] ctrl2; // Status control two
        logic level_flag; // Level-mode interrupt pending
        logic [1:0] alarm_pend; // Matches awaiting flag lag
        logic irq_a_n;
        logic irq_b_n;
        logic clkout;
        logic sec_inc;
        logic rd_ack;
        logic [7:0] rdata;
    } dev_s;

    dev_s s_r;
    dev_s s_nxt;

    // Elaboration check on divider width
    if (HALF_DIV < 2 || HALF_DIV > 1023) begin : g_bad_div
        $error("HALF_DIV out of range");
    end

    localparam logic [9:0] HALF_LAST = 10'(HALF_DIV - 1);
    localparam logic [1:0] LAG_START = 2'(rtc_pkg::SEC_LAG_TICKS);
    localparam logic [4:0] ADJ_LAST = 5'(rtc_pkg::ADJ_PERIOD_S - 1);
    localparam logic [6:0] ADJ_CAP = 7'(rtc_pkg::ADJ_MAX_TICKS);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic half_tick; // Half crystal period elapsed
    logic tick; // One crystal period elapsed
    logic sec_event; // Seconds increment this cycle
    logic p_low; // Periodic output asserted
    logic [2:0] sel; // periodic_sel
    logic [6:0] adj_mag; // Adjustment in ticks
    logic halt_set; // Halt flag rising
    logic lvl_hit; // Selected level event at this increment

    always_comb begin
        s_nxt = s_r;
        s_nxt.sec_inc = 1'b0;
        s_nxt.rd_ack = 1'b0;
        sec_event = 1'b0;
        // Crystal time base
        half_tick = (s_r.half_cnt == HALF_LAST);
        tick = half_tick && s_r.xtal_ph;
        if (half_tick) begin
            s_nxt.half_cnt = '0;
            s_nxt.xtal_ph = ~s_r.xtal_ph;
        end else begin
            s_nxt.half_cnt = s_r.half_cnt + 10'h001;
        end
        // Adjustment size, doubled magnitude, capped
        adj_mag = {s_r.adj[5:0], 1'b0};
        if (adj_mag > ADJ_CAP) begin
            adj_mag = ADJ_CAP;
        end
        // Sub-second divider; pulse falls at each wrap
        if (tick) begin
            if (s_r.stall != '0) begin
                s_nxt.stall = s_r.stall - 7'h01;
            end else if (s_r.sub == 15'h7fff) begin
                s_nxt.lag = LAG_START;
                s_nxt.sub = '0;
                if (s_r.sec20 == ADJ_LAST) begin
                    s_nxt.sec20 = '0;
                    // Stretch or trim the low half of the new second
                    if (s_r.adj[rtc_pkg::ADJ_SIGN]) begin
                        s_nxt.sub = {8'h00, adj_mag};
                    end else begin
                        s_nxt.stall = adj_mag;
                    end
                end else begin
                    s_nxt.sec20 = s_r.sec20 + 5'h01;
                end
            end else begin
                s_nxt.sub = s_r.sub + 15'h0001;
            end
            // Seconds increment trails the falling edge
            if (s_r.lag != '0) begin
                s_nxt.lag = s_r.lag - 2'h1;
                sec_event = (s_r.lag == 2'h1);
            end
        end
        s_nxt.sec_inc = sec_event;
        sel = s_r.ctrl1[rtc_pkg::C1_SEL_LSB +: 3];
        // Level-mode event selection
        lvl_hit = 1'b0;
        if (sel[2] && sec_event) begin
            case (sel[1:0])
                2'b00: lvl_hit = 1'b1;
                2'b01: lvl_hit = next_sec_zero;
                2'b10: lvl_hit = next_sec_zero & next_min_zero;
                default: lvl_hit = next_sec_zero & next_min_zero
                    & next_hour_zero & next_day_first;
            endcase
        end
        if (lvl_hit) begin
            s_nxt.level_flag = 1'b1;
        end
        if (!sel[2]) begin
            s_nxt.level_flag = 1'b0;
        end
        // Periodic output level, from current state
        case (sel)
            3'b000: p_low = 1'b0;
            3'b001: p_low = 1'b1;
            3'b010: p_low = ~s_r.sub[13];
            3'b011: p_low = ~s_r.sub[14];
            default: p_low = s_r.level_flag;
        endcase
        // Link read, data one cycle after the strobe
        if (link.rd_stb) begin
            s_nxt.rd_ack = 1'b1;
            if (link.addr == rtc_pkg::ADJ_ADDR) begin
                s_nxt.rdata = s_r.adj;
            end else if (link.addr == rtc_pkg::CTRL1_ADDR) begin
                s_nxt.rdata = s_r.ctrl1;
            end else if (link.addr == rtc_pkg::STATUS_CONTROL_TWO_ADDR) begin
                s_nxt.rdata = s_r.ctrl2;
                s_nxt.rdata[rtc_pkg::S2_PERIODIC] = p_low;
            end else begin
                s_nxt.rdata = 8'h00;
            end
        end
        // Link writes
        if (link.wr_stb) begin
            if (link.addr == rtc_pkg::SEC_ADDR) begin
                // Restart the second; low pulse half starts now
                s_nxt.sub = '0;
                s_nxt.stall = '0;
                s_nxt.lag = '0;
                s_nxt.sec20 = '0;
            end else if (link.addr == rtc_pkg::ADJ_ADDR) begin
                s_nxt.adj = {1'b0, link.wdata[6:0]};
            end else if (link.addr == rtc_pkg::CTRL1_ADDR) begin
                s_nxt.ctrl1 = link.wdata;
            end else if (link.addr == rtc_pkg::STATUS_CONTROL_TWO_ADDR) begin
                s_nxt.ctrl2[rtc_pkg::S2_VDROP_SEL] =
                    link.wdata[rtc_pkg::S2_VDROP_SEL];
                s_nxt.ctrl2[rtc_pkg::S2_SCRATCH] =
                    link.wdata[rtc_pkg::S2_SCRATCH];
                s_nxt.ctrl2[rtc_pkg::S2_CLKOUT_DIS_A] =
                    link.wdata[rtc_pkg::S2_CLKOUT_DIS_A];
                // Write-zero-to-clear bits; ones are ignored
                s_nxt.ctrl2[rtc_pkg::S2_SUPPLY_LOW] = s_r.ctrl2[
                    rtc_pkg::S2_SUPPLY_LOW] & link.wdata[6];
                s_nxt.ctrl2[rtc_pkg::S2_OSC_HALT] = s_r.ctrl2[
                    rtc_pkg::S2_OSC_HALT] & link.wdata[4];
                s_nxt.ctrl2[1:0] = s_r.ctrl2[1:0] & link.wdata[1:0];
                if (sel[2] && !link.wdata[rtc_pkg::S2_PERIODIC]) begin
                    s_nxt.level_flag = 1'b0;
                end
            end
        end
        // Supply-low flag sets only while clear; a same-cycle clear of a set flag wins
        if (supply_below && !s_r.ctrl2[rtc_pkg::S2_SUPPLY_LOW]) begin
            s_nxt.ctrl2[rtc_pkg::S2_SUPPLY_LOW] = 1'b1;
        end
        // New interrupt period beats a same-cycle write-zero clear
        if (lvl_hit) begin
            s_nxt.level_flag = 1'b1;
        end
        // Alarm matches, flagged after the lag, gated by enables
        s_nxt.alarm_pend = s_r.alarm_pend;
        if (tick) begin
            s_nxt.ctrl2[1:0] = s_nxt.ctrl2[1:0] | s_r.alarm_pend;
            s_nxt.alarm_pend = 2'b00;
        end
        if (weekly_match) begin
            s_nxt.alarm_pend[1] = 1'b1;
        end
        if (daily_match) begin
            s_nxt.alarm_pend[0] = 1'b1;
        end
        if (!s_nxt.ctrl1[rtc_pkg::C1_WEEKLY_EN]) begin
            s_nxt.alarm_pend[1] = 1'b0;
            s_nxt.ctrl2[rtc_pkg::S2_WEEKLY] = 1'b0;
        end
        if (!s_nxt.ctrl1[rtc_pkg::C1_DAILY_EN]) begin
            s_nxt.alarm_pend[0] = 1'b0;
            s_nxt.ctrl2[rtc_pkg::S2_DAILY] = 1'b0;
        end
        // Halt sensing, idle bus only
        halt_set = !osc_running && !link.ce
            && !s_r.ctrl2[rtc_pkg::S2_OSC_HALT];
        if (halt_set) begin
            s_nxt.ctrl2 = rtc_pkg::STATUS_CONTROL_TWO_RESET;
            s_nxt.ctrl1 = rtc_pkg::CTRL1_RESET;
            s_nxt.adj = rtc_pkg::ADJ_RESET;
            s_nxt.level_flag = 1'b0;
            s_nxt.alarm_pend = 2'b00;
        end
        // Pins from the next state, so level assert meets increment
        case (s_nxt.ctrl1[rtc_pkg::C1_SEL_LSB +: 3])
            3'b000: s_nxt.irq_a_n = 1'b1;
            3'b001: s_nxt.irq_a_n = 1'b0;
            3'b010: s_nxt.irq_a_n = s_nxt.sub[13];
            3'b011: s_nxt.irq_a_n = s_nxt.sub[14];
            default: s_nxt.irq_a_n = ~s_nxt.level_flag;
        endcase
        if (s_nxt.ctrl2[rtc_pkg::S2_WEEKLY]) begin
            s_nxt.irq_a_n = 1'b0;
        end
        s_nxt.irq_b_n = ~s_nxt.ctrl2[rtc_pkg::S2_DAILY];
        // Clock output held high only if both disables set
        s_nxt.clkout = (s_nxt.ctrl2[rtc_pkg::S2_CLKOUT_DIS_A]
            && s_nxt.ctrl1[rtc_pkg::C1_CLKOUT_DIS_B])
            ? 1'b1 : s_nxt.xtal_ph;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.ctrl2 <= rtc_pkg::STATUS_CONTROL_TWO_RESET;
            s_r.irq_a_n <= 1'b1;
            s_r.irq_b_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.rdata = s_r.rdata;
    assign link.rd_ack = s_r.rd_ack;
    assign link.irq_out_a_n = s_r.irq_a_n;
    assign link.irq_out_b_n = s_r.irq_b_n;
    assign link.clkout_pin = s_r.clkout;
    assign vdrop_threshold_sel = s_r.ctrl2[rtc_pkg::S2_VDROP_SEL];
    assign sec_inc = s_r.sec_inc;
endmodule
`default_nettype wire

// [rtl/rtc_host.sv]
// Purpose: AHB-Lite controller that drives the clock device link.
// Assumes: Zero-wait slave, single word transfers.
// Notes:   One link command at a time; commands while busy are dropped.
`timescale 1ns/1ps
`default_nettype none
module rtc_host (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    rtc_link_if.host link
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        rtc_pkg::host_state_e st; // Link sequencer
        logic wr_pend; // Data phase of a command write
        logic is_read; // Current command reads
        logic [3:0] addr; // Link address
        logic [7:0] wdata; // Link write data
        logic [7:0] rdata; // Last read data
        logic ce;
        logic wr_stb;
        logic rd_stb;
        logic [31:0] hrdata;
    } host_s;

    host_s s_r;
    host_s s_nxt;
    logic busy; // Sequencer active

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.wr_stb = 1'b0;
        s_nxt.rd_stb = 1'b0;
        busy = (s_r.st != rtc_pkg::H_IDLE);
        // Address phase decode
        s_nxt.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            if (hwrite) begin
                s_nxt.wr_pend = (haddr == rtc_pkg::HOST_CMD_OFS);
            end else if (haddr == rtc_pkg::HOST_STAT_OFS) begin
                s_nxt.hrdata = {21'h000000, ~link.irq_out_b_n,
                    ~link.irq_out_a_n, busy, s_r.rdata};
            end else begin
                s_nxt.hrdata = 32'h00000000;
            end
        end
        // Sequencer
        case (s_r.st)
            rtc_pkg::H_IDLE: begin
                // Software clears device flags by writing zero to them
                if (s_r.wr_pend) begin
                    s_nxt.is_read = hwdata[rtc_pkg::CMD_READ_BIT];
                    s_nxt.addr = hwdata[rtc_pkg::CMD_ADDR_LSB +: 4];
                    s_nxt.wdata = hwdata[7:0];
                    s_nxt.ce = 1'b1;
                    s_nxt.st = rtc_pkg::H_CE_ON;
                end
            end
            rtc_pkg::H_CE_ON: begin
                s_nxt.wr_stb = ~s_r.is_read;
                s_nxt.rd_stb = s_r.is_read;
                s_nxt.st = rtc_pkg::H_STROBE;
            end
            rtc_pkg::H_STROBE: begin
                s_nxt.st = s_r.is_read ? rtc_pkg::H_WAIT : rtc_pkg::H_CE_OFF;
            end
            rtc_pkg::H_WAIT: begin
                if (link.rd_ack) begin
                    s_nxt.rdata = link.rdata;
                    s_nxt.st = rtc_pkg::H_CE_OFF;
                end
            end
            rtc_pkg::H_CE_OFF: begin
                s_nxt.ce = 1'b0;
                s_nxt.st = rtc_pkg::H_IDLE;
            end
            default: begin
                s_nxt.ce = 1'b0;
                s_nxt.st = rtc_pkg::H_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.st <= rtc_pkg::H_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hrdata = s_r.hrdata;
    assign hreadyout = 1'b1; // Always zero wait
    assign hresp = 1'b0; // Always OKAY
    assign link.ce = s_r.ce;
    assign link.wr_stb = s_r.wr_stb;
    assign link.rd_stb = s_r.rd_stb;
    assign link.addr = s_r.addr;
    assign link.wdata = s_r.wdata;
endmodule
`default_nettype wire

// [testbench/rtc_link_properties.sv]
// Purpose: Link protocol checks between host and clock device.
// Assumes: One hclk domain; strobes one cycle wide.
// Notes:   Watches the interface signals only.
`timescale 1ns/1ps
`default_nettype none
module rtc_link_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rd_ack,
    input wire logic irq_out_a_n,
    input wire logic irq_out_b_n,
    input wire logic clkout_pin
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Read answered exactly one cycle later
    ack_after_read_a: assert property (rd_stb |=> rd_ack)
        else $error("rd_ack missing after rd_stb");
    ack_cause_a: assert property (rd_ack |-> $past(rd_stb))
        else $error("rd_ack without rd_stb");
    strobe_in_ce_a: assert property ((wr_stb || rd_stb) |-> ce)
        else $error("strobe outside chip enable");
    strobe_pulse_a: assert property (wr_stb |=> !wr_stb && !rd_stb)
        else $error("write strobe longer than one cycle");
    cmd_hold_a: assert property (ce && $past(ce) |-> $stable({addr, wdata}))
        else $error("address or data moved during command");
    rdata_hold_a: assert property ($changed(rdata) |-> rd_ack)
        else $error("read data moved without rd_ack");
    ce_strobe_a: assert property ($rose(ce) |=> wr_stb || rd_stb)
        else $error("no strobe after chip enable");
    // High phase lasts at least two cycles
    clk_high_a: assert property ($rose(clkout_pin) |=> clkout_pin)
        else $error("clock output high phase too short");
    cover property (rd_ack);
    cover property (!irq_out_a_n);
    cover property (!irq_out_b_n);
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Purpose: Drives the host over AHB and checks the device registers.
// Assumes: HALF_DIV of 2, so one crystal tick is four hclk cycles.
// Notes:   Second-long waveforms are checked neither here nor by the checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00, d, k;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, r;
    logic hreadyout, sel_out, osc = 1'b1, sup = 1'b0, wm = 1'b0, dm = 1'b0;
    logic nz = 1'b1, si;
    int n_fail = 0, compares = 0, i;
    rtc_link_if link();
    always #12.5 hclk = ~hclk;
    rtc_device #(.HALF_DIV(2)) u_rtc_device (.hclk, .hresetn, .link,
        .osc_running(osc), .supply_below(sup), .weekly_match(wm),
        .daily_match(dm), .next_sec_zero(nz), .next_min_zero(nz),
        .next_hour_zero(nz), .next_day_first(nz),
        .vdrop_threshold_sel(sel_out), .sec_inc(si));
    rtc_host u_rtc_host (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp(), .link);
    rtc_link_properties u_rtc_link_properties (.hclk, .hresetn,
        .ce(link.ce), .wr_stb(link.wr_stb), .rd_stb(link.rd_stb),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
        .rd_ack(link.rd_ack), .irq_out_a_n(link.irq_out_a_n),
        .irq_out_b_n(link.irq_out_b_n), .clkout_pin(link.clkout_pin));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    // One AHB single transfer; r holds the read data
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // Link command, then poll busy; d gets the last read byte
    task automatic xfer(input logic rd, input logic [3:0] a,
                        input logic [7:0] v);
        ahb(1'b1, 8'h00, {15'h0, rd, 4'h0, a, v});
        repeat (2) @(posedge hclk);
        do ahb(1'b0, 8'h04, 32'h0); while (r[8] !== 1'b0);
        d = r[7:0];
    endtask
    task automatic pins(input logic [1:0] e);
        ahb(1'b0, 8'h04, 32'h0);
        chk({6'h0, r[10:9]}, {6'h0, e});
    endtask
    task automatic end_of_test;
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #1_000_000;
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1, 4'hf, 0);
        chk(d, 8'h10);
        xfer(1, 4'he, 0);
        chk(d, 8'h00);
        xfer(1, 4'h7, 0);
        chk(d, 8'h00);
        xfer(0, 4'hf, 8'h10);
        xfer(1, 4'hf, 0);
        chk(d, 8'h10);
        xfer(0, 4'hf, 8'ha8);
        xfer(1, 4'hf, 0);
        chk(d, 8'ha8);
        chk({7'h0, sel_out}, 8'h01);
        sup <= 1'b1;
        repeat (20) @(posedge hclk);
        xfer(1, 4'hf, 0);
        chk(d, 8'he8);
        sup <= 1'b0;
        xfer(0, 4'hf, 8'he8);
        xfer(1, 4'hf, 0);
        chk(d, 8'he8);
        xfer(0, 4'hf, 8'ha8);
        xfer(1, 4'hf, 0);
        chk(d, 8'ha8);
        xfer(0, 4'he, 8'h10);
        // Pins are looked at mid-cycle, where they are settled
        repeat (8) begin
            @(negedge hclk);
            chk({7'h0, link.clkout_pin}, 8'h01);
        end
        @(posedge hclk);
        xfer(0, 4'hf, 8'ha0);
        k = 8'h00;
        repeat (8) begin
            @(negedge hclk);
            k = k + {7'h0, link.clkout_pin};
        end
        @(posedge hclk);
        chk(k, 8'h04);
        for (i = 0; i < 2; i++) begin
            {wm, dm} <= 2'b10 >> i;
            repeat (20) @(posedge hclk);
            {wm, dm} <= 2'b00;
            xfer(1, 4'hf, 0);
            chk(d, 8'ha0);
            xfer(0, 4'he, 8'h10 | (8'h80 >> i));
            {wm, dm} <= 2'b10 >> i;
            repeat (20) @(posedge hclk);
            {wm, dm} <= 2'b00;
            xfer(1, 4'hf, 0);
            chk(d, 8'ha0 | (8'h02 >> i));
            pins(2'b01 << i);
            xfer(0, 4'hf, 8'ha0);
            xfer(1, 4'hf, 0);
            chk(d, 8'ha0);
            pins(2'b00);
            xfer(0, 4'he, 8'h10);
        end
        xfer(0, 4'he, 8'h11);
        pins(2'b01);
        xfer(1, 4'hf, 0);
        chk(d, 8'ha4);
        xfer(0, 4'he, 8'h10);
        pins(2'b00);
        xfer(0, 4'he, 8'h12);
        xfer(0, 4'h0, 8'h00);
        pins(2'b01);
        xfer(0, 4'hf, 8'ha0);
        pins(2'b01);
        // Quarter of a second on: 2 Hz pin high, no increment yet
        k = 8'h00;
        repeat (32800) begin
            @(negedge hclk);
            k = k + {7'h0, si};
        end
        @(posedge hclk);
        chk(k, 8'h00);
        pins(2'b00);
        osc <= 1'b0;
        repeat (10) @(posedge hclk);
        osc <= 1'b1;
        xfer(1, 4'hf, 0);
        chk(d, 8'h10);
        chk({7'h0, sel_out}, 8'h00);
        xfer(1, 4'he, 0);
        chk(d, 8'h00);
        pins(2'b00);
        k = 8'h00;
        repeat (8) begin
            @(negedge hclk);
            k = k + {7'h0, link.clkout_pin};
        end
        @(posedge hclk);
        chk(k, 8'h04);
        end_of_test();
    end
endmodule
`default_nettype wire
